/* hw/clock_startup_pkg.sv */
// constants, types and register map of the system clock source and start-up block
package clock_startup_pkg;

  // ****************************************************************
  // register map (byte addresses) and field layout
  // ****************************************************************
  localparam logic [4:0] OFS_PERIPH_DIV = 5'h00;
  localparam logic [4:0] OFS_CPU_DIV    = 5'h04;
  localparam logic [4:0] OFS_SETTLE_SEL = 5'h08;
  localparam logic [4:0] OFS_STATUS     = 5'h0c;
  localparam logic [4:0] OFS_PORT       = 5'h10;
  localparam logic [4:0] OFS_STOP       = 5'h14;

  localparam int STAT_SRC_LSB    = 0;
  localparam int STAT_RUN_BIT    = 2;
  localparam int STAT_SETTLE_BIT = 3;
  localparam int STAT_STOP_BIT   = 4;
  localparam int PORT_OUT_LSB    = 0;
  localparam int PORT_OE_LSB     = 2;
  localparam int PORT_PIN_LSB    = 4;
  localparam int STOP_REQ_BIT    = 0;

  // ****************************************************************
  // reset values and codes
  // ****************************************************************
  localparam logic [1:0] PERIPH_DIV_RST = 2'h2;
  localparam logic [1:0] PERIPH_DIV_BAD = 2'h3;
  localparam logic       CPU_DIV_RST    = 1'h0;
  localparam logic [1:0] SETTLE_SEL_RST = 2'h0;
  localparam logic [1:0] PORT_RST       = 2'h0;
  localparam logic [1:0] CPU_DIV_SHIFT  = 2'h2;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int SYS_CLK_HZ     = 40_000_000;
  localparam int RING_CLK_HZ    = 8_000_000;
  localparam int RING_DIV       = SYS_CLK_HZ / RING_CLK_HZ;
  localparam int RING_START_NS  = 200;
  localparam int RING_START_CYC = (RING_START_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SETTLE_EXP_00  = 10;
  localparam int SETTLE_EXP_01  = 12;
  localparam int SETTLE_EXP_10  = 15;
  localparam int SETTLE_EXP_11  = 17;
  localparam int SETTLE_CNT_W   = 18;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    SRC_RING = 2'b00,
    SRC_XTAL = 2'b01,
    SRC_EXT  = 2'b10,
    SRC_RSVD = 2'b11
  } clk_src_t;

  typedef struct packed {
    clk_src_t   src;
    logic [1:0] settle;
  } option_t;

  typedef enum logic [2:0] {
    ST_RING_UP  = 3'b000,
    ST_READ_OPT = 3'b001,
    ST_SETTLE   = 3'b010,
    ST_RUN      = 3'b011,
    ST_STOP     = 3'b100
  } start_state_t;

  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_t;

endpackage

/* hw/tick_divider.sv */
// power-of-two divider of a one-cycle tick stream
`timescale 1ns/100ps
module tick_divider
  import clock_startup_pkg::*;
#(
  parameter int CNT_W = 4
)
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       en_i,
  input  wire logic       tick_i,
  input  wire logic [1:0] shift_i,
  output logic            tick_o
);

  // ****************************************************************
  // elaboration check
  // ****************************************************************
  if (CNT_W < 3)
  begin : g_chk
    $error("tick_divider needs CNT_W of at least 3");
  end

  logic [CNT_W-1:0] cnt;
  wire  [CNT_W-1:0] mask = ~({CNT_W{1'b1}} << shift_i);
  wire              hit  = (cnt & mask) == mask;

  // count input ticks, emit one tick per 2^shift inputs
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= en_i && tick_i && hit;
      if (!en_i)
        cnt <= '0;
      else if (tick_i)
        cnt <= hit ? '0 : cnt + 1'b1;
    end
  end

endmodule

/* hw/clock_startup.sv */
// system clock source selection, start-up sequence, prescaler and oscillator pins
//
// Behaviour
// - resonator source takes both oscillator pins; neither is offered as port pin.
// - external source drives the input pin; system clock is taken from it.
// - external source frees the output oscillator pin as a port pin.
// - fast ring source frees both oscillator pins as port pins.
// - peripheral clock is the selected system clock divided down.
// - CPU clock divides the peripheral clock further, never the system clock.
// - after power-on reset, option is read and source chosen before CPU runs.
// - fast ring source starts the CPU with no stabilization wait.
// - fast ring source becomes system clock right after option read.
// - resonator start produces the ring clock first, then reads the option.
// - resonator clocks the CPU only after option-selected settle wait.
// - wake from stop takes its settle wait from the software select field.
// - external source is used as system clock right after option read.
// - stop wake waits only with resonator; otherwise no wait.
// - settle codes 00..11 give 2^10, 2^12, 2^15, 2^17 system clocks.
// - peripheral divide codes 00,01,10 give /1,/2,/4; code 11 is refused.
//
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/100ps
module clock_startup
  import clock_startup_pkg::*;
#(
  parameter int RING_DIV_P    = RING_DIV,
  parameter int SETTLE_EXP_0  = SETTLE_EXP_00,
  parameter int SETTLE_EXP_1  = SETTLE_EXP_01,
  parameter int SETTLE_EXP_2  = SETTLE_EXP_10,
  parameter int SETTLE_EXP_3  = SETTLE_EXP_11
)
(
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_I,
  input  wire logic [1:0]  OPTION_SRC_I,
  input  wire logic [1:0]  OPTION_SETTLE_I,
  input  wire logic        WAKE_I,
  input  wire logic        OSC_IN_PIN_I,
  output logic             OSC_IN_PIN_O,
  output logic             OSC_IN_PIN_OE_O,
  input  wire logic        OSC_OUT_PIN_I,
  output logic             OSC_OUT_PIN_O,
  output logic             OSC_OUT_PIN_OE_O,
  output logic             SYS_TICK_O,
  output logic             PERIPH_TICK_O,
  output logic             CPU_TICK_O,
  output logic             CPU_RUN_O,
  input  wire logic [4:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic [31:0]      AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (RING_DIV_P < 2 || RING_DIV_P > 255)
  begin : g_chk_ring
    $error("RING_DIV_P must lie in 2..255");
  end
  if (SETTLE_EXP_0 < 1 || SETTLE_EXP_1 < 1 || SETTLE_EXP_2 < 1 || SETTLE_EXP_3 < 1 ||
      SETTLE_EXP_0 > 17 || SETTLE_EXP_1 > 17 || SETTLE_EXP_2 > 17 || SETTLE_EXP_3 > 17)
  begin : g_chk_exp
    $error("settle exponents must lie in 1..17");
  end

  // ****************************************************************
  // declarations
  // ****************************************************************
  start_state_t            state;
  start_state_t            next_state;
  option_t                 option;
  logic                    opt_valid;
  logic [7:0]              ring_cnt;
  logic [7:0]              up_cnt;
  logic [SETTLE_CNT_W-1:0] settle_cnt;
  logic [4:0]              settle_exp;
  logic [4:0]              next_settle_exp;
  logic [1:0]              periph_div;
  logic                    cpu_div;
  logic [1:0]              settle_sel;
  logic [1:0]              port_out;
  logic [1:0]              port_oe;
  logic                    stop_req;
  logic                    in_meta;
  logic                    in_sync;
  logic                    in_prev;
  logic                    out_meta;
  logic                    out_sync;
  logic                    periph_tick;
  logic                    cpu_tick;

  // exponent of the settle wait for a two-bit code
  function automatic logic [4:0] exp_of(input logic [1:0] code);
    logic [4:0] e;
    e = 5'h00;
    unique case (code)
      2'b00: e = 5'(SETTLE_EXP_0);
      2'b01: e = 5'(SETTLE_EXP_1);
      2'b10: e = 5'(SETTLE_EXP_2);
      2'b11: e = 5'(SETTLE_EXP_3);
    endcase
    return e;
  endfunction

  // ****************************************************************
  // pin synchronisers and resonator / external edge detect
  // ****************************************************************
  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      in_meta  <= 1'b0;
      in_sync  <= 1'b0;
      in_prev  <= 1'b0;
      out_meta <= 1'b0;
      out_sync <= 1'b0;
    end
    else
    begin
      in_meta  <= OSC_IN_PIN_I;
      in_sync  <= in_meta;
      in_prev  <= in_sync;
      out_meta <= OSC_OUT_PIN_I;
      out_sync <= out_meta;
    end
  end

  // ****************************************************************
  // system clock tick selection
  // ****************************************************************
  wire clk_src_t src       = option.src;
  wire           is_xtal   = opt_valid && (src == SRC_XTAL);
  wire           is_ext    = opt_valid && (src == SRC_EXT);
  wire           is_ring   = opt_valid && !is_xtal && !is_ext;
  wire           osc_edge  = in_sync && !in_prev;
  wire           ring_tick = (state != ST_STOP) && (ring_cnt == 8'(RING_DIV_P - 1));
  wire           pin_clock = is_xtal || is_ext;
  wire           sys_tick  = (state == ST_STOP) ? 1'b0 : (pin_clock ? osc_edge : ring_tick);
  wire           run       = (state == ST_RUN);

  // fast ring oscillator model, runs from reset except in stop
  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
      ring_cnt <= 8'h00;
    else if (state == ST_STOP || ring_tick)
      ring_cnt <= 8'h00;
    else
      ring_cnt <= ring_cnt + 8'h01;
  end

  // ****************************************************************
  // start-up sequencer
  // ****************************************************************
  wire [SETTLE_CNT_W-1:0] settle_last = (SETTLE_CNT_W'(1) << settle_exp) - SETTLE_CNT_W'(1);
  wire                    settle_done = sys_tick && (settle_cnt == settle_last);
  wire                    ring_ready  = (up_cnt == 8'(RING_START_CYC - 1));
  wire option_t           opt_pin     = {OPTION_SRC_I, OPTION_SETTLE_I};

  // next state and the settle exponent to load
  always_comb
  begin
    next_state      = state;
    next_settle_exp = settle_exp;
    unique case (state)
      ST_RING_UP:
        if (ring_ready)
          next_state = ST_READ_OPT;
      ST_READ_OPT:
        if (opt_pin.src == SRC_XTAL)
        begin
          next_state      = ST_SETTLE;
          next_settle_exp = exp_of(OPTION_SETTLE_I);
        end
        else
          next_state = ST_RUN;
      ST_SETTLE:
        if (settle_done)
          next_state = ST_RUN;
      ST_RUN:
        if (stop_req)
          next_state = ST_STOP;
      ST_STOP:
        if (WAKE_I && is_xtal)
        begin
          next_state      = ST_SETTLE;
          next_settle_exp = exp_of(settle_sel);
        end
        else if (WAKE_I)
          next_state = ST_RUN;
      default:
        next_state = ST_RING_UP;
    endcase
  end

  // state, option capture and counters
  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      state      <= ST_RING_UP;
      option     <= '0;
      opt_valid  <= 1'b0;
      up_cnt     <= 8'h00;
      settle_cnt <= '0;
      settle_exp <= 5'h00;
    end
    else
    begin
      state      <= next_state;
      settle_exp <= next_settle_exp;
      if (state == ST_RING_UP)
        up_cnt <= up_cnt + 8'h01;
      if (state == ST_READ_OPT)
      begin
        option    <= {OPTION_SRC_I, OPTION_SETTLE_I};
        opt_valid <= 1'b1;
      end
      if (state != ST_SETTLE)
        settle_cnt <= '0;
      else if (sys_tick)
        settle_cnt <= settle_cnt + SETTLE_CNT_W'(1);
    end
  end

  // ****************************************************************
  // prescaler: peripheral clock, then CPU clock from it
  // ****************************************************************
  tick_divider #(.CNT_W(4)) u_periph_div
  (
    .clk_i   (SYS_CLK_I),
    .rst_i   (RST_I),
    .en_i    (1'b1),
    .tick_i  (sys_tick),
    .shift_i (periph_div),
    .tick_o  (periph_tick)
  );

  tick_divider #(.CNT_W(4)) u_cpu_div
  (
    .clk_i   (SYS_CLK_I),
    .rst_i   (RST_I),
    .en_i    (run),
    .tick_i  (periph_tick),
    .shift_i (cpu_div ? CPU_DIV_SHIFT : 2'h0),
    .tick_o  (cpu_tick)
  );

  assign PERIPH_TICK_O = periph_tick;
  assign CPU_TICK_O    = cpu_tick;

  // ****************************************************************
  // oscillator pin use
  // ****************************************************************
  pin_drive_t in_drv;
  pin_drive_t out_drv;
  // packed drive pairs, value first and enable second
  assign in_drv  = is_ring ? {port_out[0], port_oe[0]} : 2'b00;
  assign out_drv = is_xtal ? {!in_sync, 1'b1}
                 : opt_valid ? {port_out[1], port_oe[1]}
                 : 2'b00;

  // registered pin drive and status outputs
  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      OSC_IN_PIN_O     <= 1'b0;
      OSC_IN_PIN_OE_O  <= 1'b0;
      OSC_OUT_PIN_O    <= 1'b0;
      OSC_OUT_PIN_OE_O <= 1'b0;
      SYS_TICK_O       <= 1'b0;
      CPU_RUN_O        <= 1'b0;
    end
    else
    begin
      OSC_IN_PIN_O     <= in_drv.out;
      OSC_IN_PIN_OE_O  <= in_drv.oe;
      OSC_OUT_PIN_O    <= out_drv.out;
      OSC_OUT_PIN_OE_O <= out_drv.oe;
      SYS_TICK_O       <= sys_tick;
      CPU_RUN_O        <= run;
    end
  end

  // ****************************************************************
  // Avalon-MM slave: one wait state, then the answer
  // ****************************************************************
  wire        ack      = (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
  wire        wr_done  = AVS_WRITE_I && !AVS_WAITREQUEST_O;                 // write lands as the master completes
  wire        wr_lo    = wr_done && AVS_BYTEENABLE_I[0];
  wire [2:0]  word     = AVS_ADDRESS_I[4:2];
  wire        hit_pdiv = (word == OFS_PERIPH_DIV[4:2]);
  wire        hit_cdiv = (word == OFS_CPU_DIV[4:2]);
  wire        hit_ssel = (word == OFS_SETTLE_SEL[4:2]);
  wire        hit_stat = (word == OFS_STATUS[4:2]);
  wire        hit_port = (word == OFS_PORT[4:2]);
  wire        hit_stop = (word == OFS_STOP[4:2]);
  wire [31:0] stat_val = {27'h0, state == ST_STOP, state == ST_SETTLE, run, src};
  wire [31:0] port_val = {26'h0, out_sync, in_sync, port_oe, port_out};
  wire [31:0] rd_val   = hit_pdiv ? {30'h0, periph_div}
                       : hit_cdiv ? {31'h0, cpu_div}
                       : hit_ssel ? {30'h0, settle_sel}
                       : hit_stat ? stat_val
                       : hit_port ? port_val
                       : 32'h0;

  // bus handshake, register writes and stop request
  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O    <= 32'h0;
      periph_div        <= PERIPH_DIV_RST;
      cpu_div           <= CPU_DIV_RST;
      settle_sel        <= SETTLE_SEL_RST;
      port_out          <= PORT_RST;
      port_oe           <= PORT_RST;
      stop_req          <= 1'b0;
    end
    else
    begin
      AVS_WAITREQUEST_O <= !ack;
      if (ack && AVS_READ_I)
        AVS_READDATA_O <= rd_val;
      if (wr_lo && hit_pdiv && AVS_WRITEDATA_I[1:0] != PERIPH_DIV_BAD)
        periph_div <= AVS_WRITEDATA_I[1:0];
      if (wr_lo && hit_cdiv)
        cpu_div <= AVS_WRITEDATA_I[0];
      if (wr_lo && hit_ssel)
        settle_sel <= AVS_WRITEDATA_I[1:0];
      if (wr_lo && hit_port)
      begin
        port_out <= AVS_WRITEDATA_I[PORT_OUT_LSB +: 2];
        port_oe  <= AVS_WRITEDATA_I[PORT_OE_LSB +: 2];
      end
      stop_req <= wr_lo && hit_stop && AVS_WRITEDATA_I[STOP_REQ_BIT] && run;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_opt_read;
    state == ST_READ_OPT;
  endsequence
  sequence s_xtal_wake;
    state == ST_STOP && WAKE_I && is_xtal;
  endsequence

  property p_xtal_pins;
    is_xtal |=> !OSC_IN_PIN_OE_O && OSC_OUT_PIN_OE_O && OSC_OUT_PIN_O == !$past(in_sync);
  endproperty
  a_xtal_pins: assert property (p_xtal_pins) else $error("resonator pins not dedicated");

  property p_ext_tick;
    is_ext && state != ST_STOP |-> sys_tick == osc_edge;
  endproperty
  a_ext_tick: assert property (p_ext_tick) else $error("external clock not used");

  property p_ext_port;
    is_ext |=> OSC_OUT_PIN_OE_O == $past(port_oe[1]) && !OSC_IN_PIN_OE_O;
  endproperty
  a_ext_port: assert property (p_ext_port) else $error("output pin not freed");

  property p_ring_port;
    is_ring |=> OSC_IN_PIN_OE_O == $past(port_oe[0]) && OSC_OUT_PIN_O == $past(port_out[1]);
  endproperty
  a_ring_port: assert property (p_ring_port) else $error("ring pins not freed");

  property p_periph_src;
    PERIPH_TICK_O |-> $past(sys_tick);
  endproperty
  a_periph_src: assert property (p_periph_src) else $error("peripheral tick without system tick");

  property p_cpu_src;
    CPU_TICK_O |-> $past(periph_tick) && $past(run);
  endproperty
  a_cpu_src: assert property (p_cpu_src) else $error("cpu tick not from peripheral tick");

  property p_ring_start;
    s_opt_read ##0 !OPTION_SRC_I[0] |=> state == ST_RUN ##1 CPU_RUN_O;
  endproperty
  a_ring_start: assert property (p_ring_start) else $error("ring start waited");

  property p_ring_first;
    $rose(opt_valid) |-> $past(state, 2) == ST_RING_UP && $past(ring_ready, 2);
  endproperty
  a_ring_first: assert property (p_ring_first) else $error("option read before ring clock");

  property p_xtal_wait;
    $rose(run) && is_xtal |-> $past(state) == ST_SETTLE && $past(settle_done);
  endproperty
  a_xtal_wait: assert property (p_xtal_wait) else $error("cpu started before settle");

  property p_wake_sel;
    s_xtal_wake |=> state == ST_SETTLE && settle_exp == exp_of($past(settle_sel));
  endproperty
  a_wake_sel: assert property (p_wake_sel) else $error("wake wait not from select field");

  property p_wake_nowait;
    state == ST_STOP && WAKE_I && !is_xtal |=> run;
  endproperty
  a_wake_nowait: assert property (p_wake_nowait) else $error("wake waited without resonator");

  property p_src_fixed;
    opt_valid |=> opt_valid && $stable(option);
  endproperty
  a_src_fixed: assert property (p_src_fixed) else $error("source changed after option read");

endmodule

/* tb/osc_partner.sv */
// model of the resonator or external clock source on the oscillator pins
`timescale 1ns/100ps
module osc_partner
#(
  parameter int HALF_NS = 60
)
(
  output logic osc_o
);
  // ****************************************************************
  // free-running source clock
  // ****************************************************************
  // toggles while released as well, so a floating pin never looks settled
  initial osc_o = 1'b0;
  always #(HALF_NS) osc_o = ~osc_o;
endmodule

/* tb/test_system_clock_source_startup.sv */
// self-checking bench of the clock source and start-up block
`timescale 1ns/100ps
module test_system_clock_source_startup
  import clock_startup_pkg::*;
;
  // ****************************************************************
  // stimulus, pins and design
  // ****************************************************************
  logic SYS_CLK_I = 0, RST_I = 1, wake = 0, rd = 0, wr = 0;
  logic [1:0] src = 2'h0, stl = 2'h0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wd = 32'h0, q, rdat;
  logic po, in_o, in_oe, out_o, out_oe, st, pt, ct, run, wreq;
  int bad_count = 0, checks = 0, t, c;
  wire in_pin = in_oe ? in_o : po;
  wire out_pin = out_oe ? out_o : ~po;
  always #12.5 SYS_CLK_I = ~SYS_CLK_I;
  osc_partner u_osc_partner (.osc_o(po));
  clock_startup #(.SETTLE_EXP_0(2), .SETTLE_EXP_1(3), .SETTLE_EXP_2(4), .SETTLE_EXP_3(5)) u_clock_startup (
    .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .OPTION_SRC_I(src), .OPTION_SETTLE_I(stl),
    .WAKE_I(wake), .OSC_IN_PIN_I(in_pin), .OSC_IN_PIN_O(in_o), .OSC_IN_PIN_OE_O(in_oe),
    .OSC_OUT_PIN_I(out_pin), .OSC_OUT_PIN_O(out_o), .OSC_OUT_PIN_OE_O(out_oe),
    .SYS_TICK_O(st), .PERIPH_TICK_O(pt), .CPU_TICK_O(ct), .CPU_RUN_O(run),
    .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
    .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task end_of_test();
    $display("mismatches %0d checks %0d", bad_count, checks);
    if (bad_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one Avalon transfer, held until waitrequest is seen low
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    rd <= !w; wr <= w; adr <= a; wd <= d;
    do
    begin
      @(posedge SYS_CLK_I);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    if (wreq !== 1'b0)
    begin
      chk(n, 0);
      end_of_test();
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    // one edge to release, one more so registered outputs follow the write
    repeat (2) @(posedge SYS_CLK_I);
  endtask
  task reset_to(input logic [1:0] s, input logic [1:0] e);
    RST_I <= 1'b1; src <= s; stl <= e;
    repeat (4) @(posedge SYS_CLK_I);
    RST_I <= 1'b0;
  endtask
  // counts system ticks and cycles until the CPU runs
  task wait_run();
    t = 0; c = 0;
    while (run !== 1'b1 && c < 2000)
    begin
      @(posedge SYS_CLK_I);
      c++;
      if (st === 1'b1) t++;
    end
    if (run !== 1'b1)
    begin
      chk(c, 0);
      end_of_test();
    end
  endtask
  // fast ticks between two slow ticks: sys per periph, or periph per cpu
  task ratio(input bit cpu, output int n);
    int k;
    k = 0; n = 0;
    while ((cpu ? ct : pt) !== 1'b1 && k < 500)
    begin
      @(posedge SYS_CLK_I);
      k++;
    end
    do
    begin
      @(posedge SYS_CLK_I);
      k++;
      if ((cpu ? pt : st) === 1'b1) n++;
    end
    while ((cpu ? ct : pt) !== 1'b1 && k < 500);
    if (k >= 500)
    begin
      chk(k, 0);
      end_of_test();
    end
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_ring();
    int n;
    reset_to(2'h0, 2'h3);
    wait_run();
    chk(c <= 12, 1);
    bus(0, OFS_STATUS, 0);
    chk(q[2:0], 3'h4);
    src <= 2'h1;
    bus(1, OFS_STATUS, 32'h1);
    bus(0, OFS_STATUS, 0);
    chk(q[1:0], SRC_RING);
    bus(1, OFS_PORT, 32'hf);
    chk({in_oe, in_o, out_oe, out_o}, 4'hf);
    bus(0, OFS_PERIPH_DIV, 0);
    chk(q, PERIPH_DIV_RST);
    for (int i = 0; i < 4; i++)
    begin
      bus(1, OFS_PERIPH_DIV, i);
      bus(0, OFS_PERIPH_DIV, 0);
      chk(q, i == 3 ? 2'h2 : i);
      ratio(0, n);
      chk(n, i == 3 ? 4 : 1 << i);
    end
    bus(1, OFS_CPU_DIV, 32'h1);
    ratio(1, n);
    chk(n, 4);
    bus(0, 5'h1c, 0);
    chk(q, 0);
  endtask
  task t_xtal();
    reset_to(2'h1, 2'h0);
    wait_run();
    chk(t >= 4 && c >= 9, 1);
    bus(1, OFS_PORT, 32'hf);
    chk({in_oe, out_oe}, 2'h1);
    bus(1, OFS_SETTLE_SEL, 32'h3);
    bus(1, OFS_STOP, 32'h1);
    // stop request, stop state and the run flag each take one edge
    @(posedge SYS_CLK_I);
    chk(run, 0);
    wake <= 1'b1;
    @(posedge SYS_CLK_I);
    wake <= 1'b0;
    wait_run();
    chk(t >= 31 && t <= 34, 1);
  endtask
  task t_ext();
    reset_to(2'h2, 2'h3);
    wait_run();
    chk(c <= 12, 1);
    bus(0, OFS_STATUS, 0);
    chk(q[1:0], SRC_EXT);
    bus(1, OFS_PORT, 32'hf);
    chk({in_oe, out_oe, out_o}, 3'h3);
    bus(1, OFS_STOP, 32'h1);
    @(posedge SYS_CLK_I);
    chk(run, 0);
    wake <= 1'b1;
    @(posedge SYS_CLK_I);
    wake <= 1'b0;
    wait_run();
    chk(c <= 4, 1);
  endtask
  initial
  begin
    t_ring();
    t_xtal();
    t_ext();
    end_of_test();
  end
endmodule
